// ---- verilog/cpm_pkg.sv ----
// Package with register layout, reset values and codes for the clock pin mux
package cpm_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] CFG_INDEX = 12'h453;
    localparam logic [13:0] CFG_ADDR = {CFG_INDEX, 2'b00};
    localparam logic [15:0] CFG_RESET = 16'h0001;
    localparam int TXER_BIT = 15;
    localparam int DIV2_BIT = 8;
    localparam int SRC_LSB = 4;
    localparam int INV_BIT = 3;
    localparam int FUNC_LSB = 0;
    localparam logic [15:0] CFG_WMASK = 16'h81FF;
    localparam logic [2:0] FUNC_RST_STRAP_HI = 3'h0;
    localparam logic [2:0] FUNC_RST_STRAP_LO = 3'h1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Codes
    // ------------------------------------------------------------
    localparam logic [2:0] FUNC_IND2 = 3'h0;
    localparam logic [2:0] FUNC_CLKMUX = 3'h1;
    localparam logic [3:0] SRC_RESERVED = 4'hD;

    typedef struct packed {
        logic indicator2_as_tx_error_input;
        logic div2_en;
        logic [3:0] clk_source;
        logic inv_en;
        logic [2:0] pin_func;
    } cpm_cfg_t;

    typedef struct packed {
        logic indicator2;
        logic wake_packet_event;
        logic under_voltage;
        logic ptp_tx;
        logic ptp_rx;
        logic esd_event;
        logic interrupt;
    } cpm_events_t;
endpackage

// ---- verilog/cpm_src_sel.sv ----
// Clock source selector with reserved code held low
`timescale 1ns/1ps
module cpm_src_sel (
    // Source clocks, index equals select code
    input wire logic [15:0] srcs,
    // Select
    input wire logic [3:0] sel,
    // Selected source
    output logic clk_sel
);
    // Reserved code gives a static low level
    assign clk_sel = (sel == cpm_pkg::SRC_RESERVED) ? 1'b0 : srcs[sel];
endmodule

// ---- verilog/cpm_top.sv ----
// Clock output pin mux with AXI4-Lite configuration register
`timescale 1ns/1ps
module cpm_top (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [13:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [13:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Straps, pins
    input wire logic rx_data3_strap_input,
    input wire logic daisy_chain_strap,
    // Internal clock sources, index equals select code
    input wire logic [15:0] clk_sources,
    // Event indications
    input wire cpm_pkg::cpm_events_t events,
    // Indicator2 pin as transmit error input
    input wire logic indicator2_pin_level,
    output logic indicator2_pin_oe,
    output logic tx_error,
    // Clock output pin
    output logic clock_out_signal
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] pin_s1_r;
    logic [2:0] pin_s2_r;
    logic strap_seen_r;
    logic [15:0] cfg_r;
    cpm_pkg::cpm_cfg_t cfg;
    always_ff @(posedge aclk) begin
        pin_s1_r <= {indicator2_pin_level, daisy_chain_strap, rx_data3_strap_input};
        pin_s2_r <= pin_s1_r;
    end
    wire rx3_strap = pin_s2_r[0];
    wire daisy = pin_s2_r[1];

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic aw_have_r, w_have_r;
    logic [13:0] aw_addr_r;
    logic [15:0] wdata_r;
    logic [1:0] wstrb_r;
    // Word address decode shared by both directions
    function automatic logic addr_hit(input logic [13:0] a);
        addr_hit = (a[13:2] == cpm_pkg::CFG_ADDR[13:2]);
    endfunction
    wire aw_fire = s_axi_awvalid && s_axi_awready;
    wire w_fire = s_axi_wvalid && s_axi_wready;
    wire do_write = aw_have_r && w_have_r && !s_axi_bvalid;
    wire wr_hit = addr_hit(aw_addr_r);
    wire rd_hit = addr_hit(s_axi_araddr);
    wire ar_fire = s_axi_arvalid && s_axi_arready;
    wire [15:0] bmask = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}} & cpm_pkg::CFG_WMASK;
    wire [15:0] cfg_wr = (cfg_r & ~bmask) | (wdata_r & bmask);
    wire [15:0] cfg_nxt = (do_write && wr_hit) ? cfg_wr : cfg_r;
    wire [2:0] func_rst = rx3_strap ? cpm_pkg::FUNC_RST_STRAP_HI
                                    : cpm_pkg::FUNC_RST_STRAP_LO;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_addr_r <= 14'h0000;
            wdata_r <= 16'h0000;
            wstrb_r <= 2'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= cpm_pkg::RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= cpm_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_have_r && !aw_fire;
            s_axi_wready <= !w_have_r && !w_fire;
            if (aw_fire) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (w_fire) begin
                w_have_r <= 1'b1;
                wdata_r <= s_axi_wdata[15:0];
                wstrb_r <= s_axi_wstrb[1:0];
            end
            if (do_write) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? cpm_pkg::RESP_OKAY : cpm_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= !s_axi_rvalid && !ar_fire && !s_axi_arready;
            if (ar_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_hit ? {16'h0000, cfg_r} : 32'h00000000;
                s_axi_rresp <= rd_hit ? cpm_pkg::RESP_OKAY : cpm_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_r <= cpm_pkg::CFG_RESET;
            strap_seen_r <= 1'b0;
        end else if (!strap_seen_r) begin
            strap_seen_r <= 1'b1;
            cfg_r <= {cfg_r[15:3], func_rst};
        end else if (daisy) begin
            cfg_r <= {cfg_nxt[15:3], cpm_pkg::FUNC_IND2};
        end else begin
            cfg_r <= cfg_nxt;
        end
    end
    assign cfg = cfg_r[cpm_pkg::TXER_BIT:cpm_pkg::TXER_BIT] == 1'b1
        ? {1'b1, cfg_r[8:0]} : {1'b0, cfg_r[8:0]};

    // ------------------------------------------------------------
    // Clock path
    // ------------------------------------------------------------
    logic clk_raw;
    logic div2_r;
    logic src_d_r;
    cpm_src_sel u_src (
        .srcs(clk_sources),
        .sel(cfg.clk_source),
        .clk_sel(clk_raw)
    );
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_d_r <= 1'b0;
            div2_r <= 1'b0;
        end else begin
            src_d_r <= clk_raw;
            if (clk_raw && !src_d_r) begin
                div2_r <= !div2_r;
            end
        end
    end
    wire clk_div = cfg.div2_en ? div2_r : clk_raw;
    wire clk_mux = clk_div ^ cfg.inv_en;

    // ------------------------------------------------------------
    // Pin function select
    // ------------------------------------------------------------
    logic pin_sel;
    always_comb begin
        case (cfg.pin_func)
            3'h0: pin_sel = events.indicator2;
            3'h1: pin_sel = clk_mux;
            3'h2: pin_sel = events.wake_packet_event;
            3'h3: pin_sel = events.under_voltage;
            3'h4: pin_sel = events.ptp_tx;
            3'h5: pin_sel = events.ptp_rx;
            3'h6: pin_sel = events.esd_event;
            default: pin_sel = events.interrupt;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clock_out_signal <= 1'b0;
            indicator2_pin_oe <= 1'b1;
            tx_error <= 1'b0;
        end else begin
            clock_out_signal <= pin_sel;
            indicator2_pin_oe <= !cfg.indicator2_as_tx_error_input;
            tx_error <= cfg.indicator2_as_tx_error_input & pin_s2_r[2];
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_txer_pin_oe: assert property (@(posedge aclk) disable iff (!aresetn)
        cfg_r[15] |=> !indicator2_pin_oe)
        else $error("indicator2 pin driven while used as input");
    a_rsvd_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        cfg_r[14:9] == 6'h00)
        else $error("reserved bits not zero");
    a_daisy_force: assert property (@(posedge aclk) disable iff (!aresetn)
        (strap_seen_r && daisy) |=> cfg_r[2:0] == 3'h0)
        else $error("function select not forced by daisy strap");
    a_strap_reset: assert property (@(posedge aclk)
        (!aresetn ##1 aresetn) |=> cfg_r[2:0] == (rx3_strap ? 3'h0 : 3'h1) || daisy)
        else $error("strap reset value wrong");
    a_reset_value: assert property (@(posedge aclk)
        !aresetn |=> cfg_r == 16'h0001)
        else $error("register reset value wrong");
    a_rsvd_low: assert property (@(posedge aclk) disable iff (!aresetn)
        (cfg_r[7:4] == 4'hD && cfg_r[2:0] == 3'h1 && !cfg_r[8] && !cfg_r[3])
        |=> !clock_out_signal)
        else $error("reserved source not low");
    a_clk_route: assert property (@(posedge aclk) disable iff (!aresetn)
        (cfg_r[2:0] == 3'h1 && !cfg_r[8]) |=> clock_out_signal == $past(clk_raw ^ cfg_r[3]))
        else $error("clock mux path wrong");
    a_event_route: assert property (@(posedge aclk) disable iff (!aresetn)
        cfg_r[2:0] == 3'h2 |=> clock_out_signal == $past(events.wake_packet_event))
        else $error("wake event not routed");
    a_src_pick: assert property (@(posedge aclk) disable iff (!aresetn)
        cfg_r[7:4] == 4'h0 |-> clk_raw == clk_sources[0])
        else $error("source select wrong");
endmodule

// ---- sim/cpm_board_model.sv ----
// Board-side model: clock sources, event levels and output edge counter
`timescale 1ns/1ps
module cpm_board_model (
    // Clock
    input wire logic aclk,
    // Bench controls
    input wire logic [15:0] src_level,
    input wire logic run,
    input wire logic [6:0] ev_level,
    // Device side
    output logic [15:0] clk_sources,
    output cpm_pkg::cpm_events_t events,
    input wire logic clock_out_signal,
    output logic [7:0] rise_cnt
);
    logic [1:0] div_r = 2'h0;
    logic tog_r = 1'b0;
    logic last_r = 1'b0;
    logic [7:0] cnt_r = 8'h00;
    // Source 0 runs at one eighth of aclk when run is high
    assign clk_sources = run ? {src_level[15:1], tog_r} : src_level;
    assign events = ev_level;
    assign rise_cnt = cnt_r;
    always_ff @(posedge aclk) begin
        div_r <= div_r + 2'h1;
        if (div_r == 2'h3) begin
            tog_r <= ~tog_r;
        end
        last_r <= clock_out_signal;
        if (clock_out_signal && !last_r) begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
endmodule

// ---- sim/clock_output_pin_mux_tb.sv ----
// Testbench for the clock output pin mux
`timescale 1ns/1ps
module clock_output_pin_mux_tb;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, strap = 1'b0, daisy = 1'b0, pin = 1'b0, run = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, oe, txe, cko;
    logic [13:0] awaddr = 14'h0000, araddr = 14'h0000;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [1:0] bresp, rresp, br;
    logic [15:0] src = 16'h0000, srcs;
    logic [6:0] ev = 7'h00;
    logic [7:0] rc, r0;
    cpm_pkg::cpm_events_t evs;
    int miscompares = 0, checks_done = 0, cyc = 0;
    always #12.5 aclk = ~aclk;
    cpm_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .rx_data3_strap_input(strap), .daisy_chain_strap(daisy), .clk_sources(srcs),
        .events(evs), .indicator2_pin_level(pin), .indicator2_pin_oe(oe), .tx_error(txe),
        .clock_out_signal(cko));
    cpm_board_model board (.aclk(aclk), .src_level(src), .run(run), .ev_level(ev),
        .clk_sources(srcs), .events(evs), .clock_out_signal(cko), .rise_cnt(rc));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            miscompares++;
        end
    endtask
    task automatic wr(input logic [13:0] a, input logic [31:0] v);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                aw = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        br = bresp;
    endtask
    task automatic rd(input logic [13:0] a, output logic [31:0] v, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        v = rdata;
        r = rresp;
    endtask
    task automatic wait_pin(input logic exp);
        repeat (3) @(posedge aclk);
        chk({31'h0, cko}, {31'h0, exp});
    endtask
    task automatic print_verdict;
        $display("comparisons %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            print_verdict();
        end
    end
    initial begin
        logic [1:0] r;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(cpm_pkg::CFG_ADDR, d, r);
        chk(d, 32'h0001);
        wr(cpm_pkg::CFG_ADDR, 32'hFFFF);
        chk({30'h0, br}, {30'h0, cpm_pkg::RESP_OKAY});
        rd(cpm_pkg::CFG_ADDR, d, r);
        chk(d, 32'h81FF);
        $display("test registers done");
        wr(cpm_pkg::CFG_ADDR, 32'h8001);
        pin <= 1'b1;
        repeat (4) @(posedge aclk);
        chk({30'h0, oe, txe}, 32'h1);
        wr(cpm_pkg::CFG_ADDR, 32'h0001);
        repeat (2) @(posedge aclk);
        chk({30'h0, oe, txe}, 32'h2);
        $display("test tx error done");
        for (int c = 0; c < 16; c++) begin
            for (int i = 0; i < 2; i++) begin
                src <= 16'h1 << c;
                wr(cpm_pkg::CFG_ADDR, {24'h0, c[3:0], i[0], 3'h1});
                if (c == 13 && i == 0) wait_pin(1'b0);
                else if (c != 13) wait_pin(~i[0]);
            end
        end
        $display("test sources done");
        run <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            wr(cpm_pkg::CFG_ADDR, {23'h0, i[0], 8'h01});
            repeat (16) @(posedge aclk);
            r0 = rc;
            repeat (64) @(posedge aclk);
            chk({24'h0, rc - r0}, i ? 32'h4 : 32'h8);
        end
        run <= 1'b0;
        $display("test divide done");
        for (int f = 0; f < 8; f++) begin
            if (f != 1) begin
                ev <= 7'h1 << (f == 0 ? 6 : 7 - f);
                wr(cpm_pkg::CFG_ADDR, f);
                wait_pin(1'b1);
                ev <= ~(7'h1 << (f == 0 ? 6 : 7 - f));
                wait_pin(1'b0);
            end
        end
        $display("test functions done");
        daisy <= 1'b1;
        wr(cpm_pkg::CFG_ADDR, 32'h0012);
        rd(cpm_pkg::CFG_ADDR, d, r);
        chk(d, 32'h0010);
        daisy <= 1'b0;
        rd(14'h0000, d, r);
        chk(d, 32'h0);
        chk({30'h0, r}, {30'h0, cpm_pkg::RESP_SLVERR});
        wr(14'h0000, 32'h0003);
        chk({30'h0, br}, {30'h0, cpm_pkg::RESP_SLVERR});
        rd(cpm_pkg::CFG_ADDR, d, r);
        chk(d, 32'h0010);
        strap <= 1'b1;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(cpm_pkg::CFG_ADDR, d, r);
        chk(d, 32'h0000);
        $display("test straps done");
        print_verdict();
    end
endmodule
